// *** core/gpvr_pkg.sv ***
// Package: register offsets, field positions, reset values, timing counts and carrier structs
// Assumes a 10 MHz management core clock.
package gpvr_pkg;
    localparam int CLK_HZ = 10000000;
    localparam logic [4:0] OFF_GIG_STATUS = 5'h0a;
    localparam logic [4:0] OFF_EXT_STATUS = 5'h0f;
    localparam logic [4:0] OFF_SPEC_CTRL = 5'h10;
    localparam logic [4:0] OFF_SPEC_STATUS = 5'h11;
    localparam logic [4:0] OFF_INT_ENABLE = 5'h12;
    localparam logic [4:0] OFF_INT_STATUS = 5'h13;
    localparam logic [4:0] OFF_PAIR_CTRL = 5'h14;
    localparam logic [4:0] OFF_RX_ERR_CNT = 5'h15;
    localparam logic [4:0] OFF_OS_SELECT = 5'h16;
    localparam logic [4:0] OFF_CABLE_LEN = 5'h17;
    localparam logic [4:0] OFF_LED_ONE = 5'h18;
    localparam logic [4:0] OFF_LED_TWO = 5'h19;
    localparam logic [4:0] OFF_CONFIG = 5'h1b;
    localparam logic [15:0] EXT_STATUS_VALUE = 16'h3000;
    localparam logic [15:0] SPEC_CTRL_MASK = 16'h1f3e;
    localparam logic [15:0] INT_MASK = 16'hfcde;
    localparam logic [7:0] IDLE_ERR_MAX = 8'hff;
    localparam logic [15:0] RX_ERR_MAX = 16'hffff;
    localparam logic [2:0] BLINK_RST = 3'h1;
    localparam logic [4:0] FLP_GAP_RST = 5'h0d;
    localparam logic [2:0] STRETCH_RST = 3'h2;
    localparam logic [3:0] LED2_MODE_RST = 4'h1;
    localparam logic [3:0] LED_MODE_INT = 4'h2;
    localparam logic [3:0] LED_MODE_OFF = 4'h8;
    localparam logic [3:0] LED_MODE_ON = 4'h9;
    localparam logic [3:0] LED_MODE_BLINK = 4'hb;
    localparam int BLINK_BASE_MS = 42;
    localparam int BLINK_BASE_CYC = BLINK_BASE_MS * (CLK_HZ / 1000);
    localparam int FLP_UNIT_MS = 1;
    localparam int FLP_UNIT_CYC = FLP_UNIT_MS * (CLK_HZ / 1000);
    localparam int SLEEP_BASE_S = 4;
    localparam int SLEEP_STEP_CYC = CLK_HZ;
    localparam int RXC_PD_HZ = 2500000;
    localparam int RXC_PD_HALF_CYC = CLK_HZ / RXC_PD_HZ / 2;
    localparam int PIN_SYNC = 2;

    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } gpvr_req_type;

    typedef struct packed {
        logic [1:0] speed;
        logic duplex;
        logic resolved;
        logic link_up;
        logic crossover;
        logic pol_10bt;
        logic [3:0] pair_pol;
        logic ab_cross;
        logic cd_cross;
        logic an_done;
        logic lp_gig_full;
        logic lp_gig_half;
        logic gig_mode;
        logic activity;
        logic transmit;
        logic power_down;
    } gpvr_stat_type;
endpackage

// *** core/gpvr_led_drv.sv ***
// One indicator pin: polarity encoding to output and enable
// Assumes on state is computed in the core clock domain.
`timescale 1ns/1ps
module gpvr_led_drv
    import gpvr_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_on,
    input wire logic [1:0] i_pol,
    output logic o_pin,
    output logic o_pin_oe
);
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pin <= 1'b1;
            o_pin_oe <= 1'b1;
        end
        else
        begin
            o_pin <= (i_on == i_pol[0]);
            o_pin_oe <= i_on | ~i_pol[1];
        end
    end

    led_float_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_pol[1] && !i_on) |=> !o_pin_oe) else $error("Indicator not floating when off");
endmodule

// *** core/gpvr_core.sv ***
// Vendor management register bank of a tri-speed copper transceiver
// Assumes a word request port from the management frame engine and synchronous status inputs.
`timescale 1ns/1ps
module gpvr_core
    import gpvr_pkg::*;
#(
    parameter int BLINK_CYC = BLINK_BASE_CYC,
    parameter int FLP_CYC = FLP_UNIT_CYC,
    parameter int SLEEP_CYC = SLEEP_STEP_CYC
)
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire gpvr_req_type i_req,
    input wire gpvr_stat_type i_stat,
    input wire logic [11:0] i_int_event,
    input wire logic i_idle_err,
    input wire logic i_rx_dv,
    input wire logic i_rx_er,
    input wire logic i_strap_force_mdi,
    input wire logic [15:0] i_cable_len,
    input wire logic i_cable_len_we,
    input wire logic i_sleep_start,
    input wire logic i_line_clk,
    output logic [15:0] o_rdata,
    output logic o_interrupt,
    output logic o_force_gig,
    output logic o_force_master,
    output logic o_fifo_bypass,
    output logic o_pol_manual,
    output logic o_pol_invert,
    output logic o_mdi_force,
    output logic o_mdi_cross,
    output logic [1:0] o_os_channel,
    output logic o_rxc_pd,
    output logic o_rxc_pd_en,
    output logic o_sleep_done,
    output logic o_flp_tick,
    output logic o_line_edge,
    output logic o_indicator_zero,
    output logic o_indicator_zero_oe,
    output logic o_indicator_one,
    output logic o_indicator_one_oe,
    output logic o_indicator_two,
    output logic o_indicator_two_oe
);
    logic [15:0] spec_ctrl;
    logic [15:0] int_enable;
    logic [15:0] int_status;
    logic [7:0] idle_cnt;
    logic [15:0] rx_err_cnt;
    logic lp_full;
    logic lp_half;
    logic mdi_en;
    logic mdi_sel;
    logic strap_taken;
    logic [1:0] os_sel;
    logic [15:0] cable_len;
    logic [15:0] led_one;
    logic [15:0] led_two;
    logic int_low;
    logic [PIN_SYNC-1:0] line_sync;
    logic line_prev;
    logic [31:0] blink_cnt;
    logic blink_state;
    logic [31:0] flp_cnt;
    logic [4:0] flp_units;
    logic [31:0] stretch_cnt;
    logic [31:0] sleep_cnt;
    logic sleep_run;
    logic [2:0] rxc_cnt;
    logic [15:0] next_int_status;
    logic int_any;
    logic led_on [3];

    wire logic wr = i_req.wr;
    wire logic rd = i_req.rd;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] off, input logic s);
        hit = s && (a == off);
    endfunction

    function automatic logic [31:0] pow_cycles(input int base, input logic [2:0] sh);
        pow_cycles = 32'(base) << sh;
    endfunction

    // Control register; master and invert need their enable bits, bypass is gated off in gigabit mode
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            spec_ctrl <= 16'h0000;
        else if (hit(i_req.addr, OFF_SPEC_CTRL, wr))
            spec_ctrl <= i_req.wdata & SPEC_CTRL_MASK;
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_force_gig <= 1'b0;
            o_force_master <= 1'b0;
            o_fifo_bypass <= 1'b0;
            o_pol_manual <= 1'b0;
            o_pol_invert <= 1'b0;
            o_mdi_force <= 1'b0;
            o_mdi_cross <= 1'b0;
            o_os_channel <= 2'h0;
        end
        else
        begin
            o_force_gig <= spec_ctrl[11];
            o_force_master <= spec_ctrl[11] & spec_ctrl[12];
            o_fifo_bypass <= spec_ctrl[10] & ~i_stat.gig_mode;
            o_pol_manual <= spec_ctrl[3];
            o_pol_invert <= spec_ctrl[3] & spec_ctrl[4];
            o_mdi_force <= mdi_en;
            o_mdi_cross <= mdi_en & mdi_sel;
            o_os_channel <= os_sel;
        end
    end

    // Interrupt enable and latched status; set wins over read clear
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            int_enable <= 16'h0000;
        else if (hit(i_req.addr, OFF_INT_ENABLE, wr))
            int_enable <= i_req.wdata & INT_MASK;
    end

    always_comb
    begin
        next_int_status = int_status;
        if (hit(i_req.addr, OFF_INT_STATUS, rd))
            next_int_status = 16'h0000;
        next_int_status = next_int_status | ({i_int_event[11:6], 2'b00, i_int_event[5:4], 1'b0,
            i_int_event[3:0], 1'b0} & INT_MASK);
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            int_status <= 16'h0000;
        else
            int_status <= next_int_status;
    end

    assign int_any = |(int_status & int_enable);

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            int_low <= 1'b0;
        else if (hit(i_req.addr, OFF_CONFIG, wr))
            int_low <= i_req.wdata[9];
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            o_interrupt <= 1'b0;
        else
            o_interrupt <= int_any ^ int_low;
    end

    int_level_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        ##1 (o_interrupt == ($past(int_any) ^ $past(int_low)))) else $error("Interrupt level wrong");

    sequence evt_seen_s;
        i_int_event[0] && !hit(i_req.addr, OFF_INT_STATUS, rd);
    endsequence
    int_latch_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        evt_seen_s ##1 !hit(i_req.addr, OFF_INT_STATUS, rd) |=> int_status[1]) else $error("Status not held");

    // Saturating counters cleared on read; a coincident event restarts at one
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            idle_cnt <= 8'h00;
        else if (hit(i_req.addr, OFF_GIG_STATUS, rd))
            idle_cnt <= {7'h00, i_idle_err & i_stat.gig_mode};
        else if (i_idle_err && i_stat.gig_mode && idle_cnt != IDLE_ERR_MAX)
            idle_cnt <= idle_cnt + 8'h01;
    end

    idle_sat_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (idle_cnt == IDLE_ERR_MAX && !hit(i_req.addr, OFF_GIG_STATUS, rd)) |=> idle_cnt == IDLE_ERR_MAX)
        else $error("Idle count wrapped");

    wire logic rx_err_hit = i_rx_er && i_rx_dv && spec_ctrl[8];

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            rx_err_cnt <= 16'h0000;
        else if (hit(i_req.addr, OFF_RX_ERR_CNT, rd))
            rx_err_cnt <= {15'h0000, rx_err_hit};
        else if (rx_err_hit && rx_err_cnt != RX_ERR_MAX)
            rx_err_cnt <= rx_err_cnt + 16'h0001;
    end

    rx_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!spec_ctrl[8] && !hit(i_req.addr, OFF_RX_ERR_CNT, rd)) |=> $stable(rx_err_cnt))
        else $error("Counter moved while disabled");

    // Partner abilities captured at negotiation completion
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lp_full <= 1'b0;
            lp_half <= 1'b0;
        end
        else if (i_stat.an_done)
        begin
            lp_full <= i_stat.lp_gig_full;
            lp_half <= i_stat.lp_gig_half;
        end
    end

    lp_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_stat.an_done |=> $stable(lp_full) && $stable(lp_half)) else $error("Partner bits moved");

    // Strap caught at first clock after reset release
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mdi_en <= 1'b0;
            mdi_sel <= 1'b0;
            strap_taken <= 1'b0;
        end
        else if (!strap_taken)
        begin
            mdi_en <= i_strap_force_mdi;
            strap_taken <= 1'b1;
        end
        else if (hit(i_req.addr, OFF_PAIR_CTRL, wr))
        begin
            mdi_en <= i_req.wdata[5];
            mdi_sel <= i_req.wdata[4];
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            os_sel <= 2'h0;
        else if (hit(i_req.addr, OFF_OS_SELECT, wr))
            os_sel <= i_req.wdata[1:0];
    end

    // Estimate loaded by the measuring logic or by software
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            cable_len <= 16'h0000;
        else if (i_cable_len_we)
            cable_len <= i_cable_len;
        else if (hit(i_req.addr, OFF_CABLE_LEN, wr))
            cable_len <= i_req.wdata;
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            led_one <= {BLINK_RST, FLP_GAP_RST, 8'h00};
            led_two <= {STRETCH_RST, 1'b0, LED2_MODE_RST, 4'h7, 4'h7};
        end
        else
        begin
            if (hit(i_req.addr, OFF_LED_ONE, wr))
                led_one <= i_req.wdata & 16'hff3f;
            if (hit(i_req.addr, OFF_LED_TWO, wr))
                led_two <= i_req.wdata & 16'hefff;
        end
    end

    // Read mux, registered
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= 16'h0000;
        else if (rd)
        begin
            case (i_req.addr)
                OFF_GIG_STATUS: o_rdata <= {4'h0, lp_full, lp_half, 2'b00, idle_cnt};
                OFF_EXT_STATUS: o_rdata <= EXT_STATUS_VALUE;
                OFF_SPEC_CTRL: o_rdata <= spec_ctrl;
                OFF_SPEC_STATUS: o_rdata <= {i_stat.speed, i_stat.duplex, 1'b0, i_stat.resolved,
                    i_stat.link_up, 3'h0, i_stat.crossover & ~i_stat.gig_mode, 4'h0,
                    i_stat.pol_10bt, 1'b0};
                OFF_INT_ENABLE: o_rdata <= int_enable;
                OFF_INT_STATUS: o_rdata <= int_status;
                OFF_PAIR_CTRL: o_rdata <= {i_stat.pair_pol, 4'h0, i_stat.ab_cross, i_stat.cd_cross,
                    mdi_en, mdi_sel, 4'h0};
                OFF_RX_ERR_CNT: o_rdata <= rx_err_cnt;
                OFF_OS_SELECT: o_rdata <= {14'h0000, os_sel};
                OFF_CABLE_LEN: o_rdata <= cable_len;
                OFF_LED_ONE: o_rdata <= led_one;
                OFF_LED_TWO: o_rdata <= led_two;
                OFF_CONFIG: o_rdata <= {6'h00, int_low, 9'h000};
                default: o_rdata <= 16'h0000;
            endcase
        end
    end

    // Line clock sampled; only the second stage feeds the edge detector
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            line_sync <= '0;
            line_prev <= 1'b0;
            o_line_edge <= 1'b0;
        end
        else
        begin
            line_sync <= {line_sync[PIN_SYNC-2:0], i_line_clk};
            line_prev <= line_sync[PIN_SYNC-1];
            o_line_edge <= line_sync[PIN_SYNC-1] & ~line_prev;
        end
    end

    // Blink timer; reserved codes behave as slowest defined step
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            blink_cnt <= 32'h0000_0000;
            blink_state <= 1'b0;
        end
        else if (blink_cnt >= pow_cycles(BLINK_CYC, (led_one[15:13] > 3'h4) ? 3'h4 : led_one[15:13]) - 1)
        begin
            blink_cnt <= 32'h0000_0000;
            blink_state <= ~blink_state;
        end
        else
            blink_cnt <= blink_cnt + 32'h0000_0001;
    end

    // Fast link pulse gap tick
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            flp_cnt <= 32'h0000_0000;
            flp_units <= 5'h00;
            o_flp_tick <= 1'b0;
        end
        else
        begin
            o_flp_tick <= 1'b0;
            if (flp_cnt >= 32'(FLP_CYC - 1))
            begin
                flp_cnt <= 32'h0000_0000;
                if (flp_units + 5'h01 >= led_one[12:8])
                begin
                    flp_units <= 5'h00;
                    o_flp_tick <= 1'b1;
                end
                else
                    flp_units <= flp_units + 5'h01;
            end
            else
                flp_cnt <= flp_cnt + 32'h0000_0001;
        end
    end

    // Activity stretch; code n gives BLINK_CYC times two to the n-1
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            stretch_cnt <= 32'h0000_0000;
        else if (i_stat.activity && led_two[15:13] != 3'h0)
            stretch_cnt <= pow_cycles(BLINK_CYC, led_two[15:13] - 3'h1);
        else if (stretch_cnt != 32'h0000_0000)
            stretch_cnt <= stretch_cnt - 32'h0000_0001;
    end

    wire logic act_seen = i_stat.activity | (stretch_cnt != 32'h0000_0000);

    // Sleep power-down timer
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sleep_cnt <= 32'h0000_0000;
            sleep_run <= 1'b0;
            o_sleep_done <= 1'b0;
        end
        else
        begin
            o_sleep_done <= 1'b0;
            if (i_sleep_start)
            begin
                sleep_cnt <= 32'(SLEEP_CYC) * (32'(SLEEP_BASE_S) + 32'(spec_ctrl[2:1])) - 32'h0000_0001;
                sleep_run <= 1'b1;
            end
            else if (sleep_run && sleep_cnt == 32'h0000_0000)
            begin
                sleep_run <= 1'b0;
                o_sleep_done <= 1'b1;
            end
            else if (sleep_run)
                sleep_cnt <= sleep_cnt - 32'h0000_0001;
        end
    end

    // Power-down receive clock divider
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rxc_cnt <= 3'h0;
            o_rxc_pd <= 1'b0;
            o_rxc_pd_en <= 1'b0;
        end
        else
        begin
            o_rxc_pd_en <= i_stat.power_down & ~spec_ctrl[5];
            if (rxc_cnt >= 3'(RXC_PD_HALF_CYC - 1))
            begin
                rxc_cnt <= 3'h0;
                o_rxc_pd <= ~o_rxc_pd & i_stat.power_down & ~spec_ctrl[5];
            end
            else
                rxc_cnt <= rxc_cnt + 3'h1;
        end
    end

    rxc_stop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_stat.power_down && spec_ctrl[5]) [*2] |=> !o_rxc_pd_en) else $error("Receive clock not stopped");

    // Indicator on states; first two use fixed link and activity views
    always_comb
    begin
        led_on[0] = i_stat.link_up;
        led_on[1] = i_stat.link_up & ~(act_seen & blink_state);
        case (led_two[11:8])
            4'h0: led_on[2] = i_stat.link_up;
            4'h1: led_on[2] = i_stat.link_up & ~(act_seen & blink_state);
            LED_MODE_INT: led_on[2] = int_any;
            4'h3: led_on[2] = act_seen;
            4'h4: led_on[2] = act_seen & blink_state;
            4'h5: led_on[2] = i_stat.transmit;
            4'h6: led_on[2] = i_stat.link_up & (i_stat.speed != 2'b01);
            4'h7: led_on[2] = i_stat.link_up & (i_stat.speed == 2'b00);
            LED_MODE_OFF: led_on[2] = 1'b0;
            LED_MODE_ON: led_on[2] = 1'b1;
            LED_MODE_BLINK: led_on[2] = blink_state;
            default: led_on[2] = 1'b0;
        endcase
    end

    led_mode_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (led_two[11:8] == LED_MODE_ON && led_one[5:4] == 2'b01) |=> o_indicator_two && o_indicator_two_oe)
        else $error("Forced on not shown");

    gpvr_led_drv u_led0 (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_on(led_on[0]),
        .i_pol(led_one[1:0]),
        .o_pin(o_indicator_zero),
        .o_pin_oe(o_indicator_zero_oe)
    );

    gpvr_led_drv u_led1 (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_on(led_on[1]),
        .i_pol(led_one[3:2]),
        .o_pin(o_indicator_one),
        .o_pin_oe(o_indicator_one_oe)
    );

    gpvr_led_drv u_led2 (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_on(led_on[2]),
        .i_pol(led_one[5:4]),
        .o_pin(o_indicator_two),
        .o_pin_oe(o_indicator_two_oe)
    );
endmodule

// *** dv/gpvr_host.sv ***
// Host model: one-cycle register requests
// Assumes requests change at the falling edge.
`timescale 1ns/1ps
module gpvr_host
    import gpvr_pkg::*;
(
    input wire logic i_mclk,
    input wire logic [15:0] i_rdata,
    output gpvr_req_type o_req
);
    initial o_req = '0;
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge i_mclk);
        o_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge i_mclk);
        o_req = '0;
    endtask
    // Data is taken two falling edges after the request edge
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge i_mclk);
        o_req = '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(negedge i_mclk);
        o_req = '0;
        @(negedge i_mclk);
        d = i_rdata;
    endtask
endmodule

// *** dv/gpvr_core_tb.sv ***
// Bench: register reads and writes with expected values
// Assumes the host model drives the request port.
`timescale 1ns/1ps
module gpvr_core_tb;
    import gpvr_pkg::*;
    logic i_mclk = 0, i_rst = 1, idle = 0, dv = 0, er = 0, lclk = 0;
    gpvr_req_type req;
    gpvr_stat_type st = '0;
    logic [11:0] ev = '0;
    logic [15:0] rdata, v;
    logic irq, fgig, fmas, strap = 0, slp = 0, clwe = 0;
    logic byp, pman, pinv, mforce, mcross, rxc, rxcen, sdone, flp, ledge, l0, l0e, l1, l1e, l2, l2e;
    logic [15:0] cl = '0;
    logic [1:0] osch;
    int num_errors = 0, check_count = 0, k, j;
    always #50 i_mclk = ~i_mclk;
    always #400 lclk = ~lclk;
    gpvr_host host (.i_mclk(i_mclk), .i_rdata(rdata), .o_req(req));
    // Short counts keep the run brief
    gpvr_core #(.BLINK_CYC(10), .FLP_CYC(4), .SLEEP_CYC(20)) uut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_req(req), .i_stat(st), .i_int_event(ev),
        .i_idle_err(idle), .i_rx_dv(dv), .i_rx_er(er), .i_strap_force_mdi(strap),
        .i_cable_len(cl), .i_cable_len_we(clwe), .i_sleep_start(slp),
        .i_line_clk(lclk), .o_rdata(rdata), .o_interrupt(irq), .o_force_gig(fgig),
        .o_force_master(fmas), .o_fifo_bypass(byp), .o_pol_manual(pman), .o_pol_invert(pinv),
        .o_mdi_force(mforce), .o_mdi_cross(mcross), .o_os_channel(osch), .o_rxc_pd(rxc),
        .o_rxc_pd_en(rxcen), .o_sleep_done(sdone), .o_flp_tick(flp), .o_line_edge(ledge),
        .o_indicator_zero(l0), .o_indicator_zero_oe(l0e), .o_indicator_one(l1), .o_indicator_one_oe(l1e),
        .o_indicator_two(l2), .o_indicator_two_oe(l2e));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic bchk(input string n, input logic e, input logic g);
        chk(n, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic rchk(input string n, input logic [4:0] a, input logic [15:0] e);
        host.rd(a, v);
        chk(n, e, v);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        #2000000;
        num_errors++;
        tally_and_finish;
    end
    initial
    begin
        cyc(6);
        i_rst = 0;
        cyc(2);
        rchk("ext", OFF_EXT_STATUS, 16'h3000);
        rchk("led1", OFF_LED_ONE, 16'h2d00);
        rchk("led2", OFF_LED_TWO, 16'h4177);
        rchk("unmap", 5'h1f, 16'h0000);
        host.wr(OFF_SPEC_CTRL, 16'h1900);
        cyc(2);
        chk("fgig", {15'h0000, fgig}, 16'h0001);
        chk("fmas", {15'h0000, fmas}, 16'h0001);
        // Errors outside valid must not count
        dv = 1;
        er = 1;
        cyc(3);
        dv = 0;
        cyc(2);
        er = 0;
        rchk("rxerr", OFF_RX_ERR_CNT, 16'h0003);
        rchk("rxclr", OFF_RX_ERR_CNT, 16'h0000);
        host.wr(OFF_SPEC_CTRL, 16'h0000);
        cyc(2);
        dv = 1;
        er = 1;
        cyc(2);
        dv = 0;
        er = 0;
        rchk("rxoff", OFF_RX_ERR_CNT, 16'h0000);
        st.gig_mode = 1;
        idle = 1;
        cyc(2);
        idle = 0;
        host.rd(OFF_GIG_STATUS, v);
        chk("idle", {8'h00, v[7:0]}, 16'h0002);
        host.wr(OFF_INT_ENABLE, 16'h0400);
        ev[6] = 1;
        cyc(1);
        ev[6] = 0;
        cyc(3);
        chk("irq", {15'h0000, irq}, 16'h0001);
        rchk("ists", OFF_INT_STATUS, 16'h0400);
        cyc(2);
        chk("irqclr", {15'h0000, irq}, 16'h0000);
        // Masked source latches but stays quiet
        ev[7] = 1;
        cyc(1);
        ev[7] = 0;
        cyc(3);
        chk("irqmask", {15'h0000, irq}, 16'h0000);
        host.wr(OFF_CONFIG, 16'h0200);
        cyc(3);
        chk("irqlow", {15'h0000, irq}, 16'h0001);
        rchk("ists2", OFF_INT_STATUS, 16'h0800);
        ev[0] = 1;
        cyc(1);
        ev[0] = 0;
        cyc(2);
        rchk("ists3", OFF_INT_STATUS, 16'h0002);
        idle = 1;
        cyc(260);
        idle = 0;
        rchk("idlesat", OFF_GIG_STATUS, 16'h00ff);
        // Partner bits must wait for negotiation to finish
        st.lp_gig_full = 1;
        st.lp_gig_half = 1;
        cyc(2);
        rchk("lpwait", OFF_GIG_STATUS, 16'h0000);
        st.an_done = 1;
        cyc(2);
        st.an_done = 0;
        st.lp_gig_full = 0;
        cyc(2);
        rchk("lpcap", OFF_GIG_STATUS, 16'h0c00);
        st.gig_mode = 0;
        st.speed = 2'b01;
        st.duplex = 1;
        st.resolved = 1;
        st.crossover = 1;
        st.pol_10bt = 1;
        cyc(1);
        rchk("sstat", OFF_SPEC_STATUS, 16'h6842);
        st.gig_mode = 1;
        rchk("sstatg", OFF_SPEC_STATUS, 16'h6802);
        host.wr(OFF_SPEC_CTRL, 16'h0418);
        cyc(2);
        bchk("byp", 1'b0, byp);
        bchk("pinv", 1'b1, pinv);
        st.gig_mode = 0;
        cyc(2);
        bchk("byp10", 1'b1, byp);
        bchk("pman", 1'b1, pman);
        st.pair_pol = 4'ha;
        st.ab_cross = 1;
        host.wr(OFF_PAIR_CTRL, 16'h0030);
        host.wr(OFF_OS_SELECT, 16'h0003);
        cyc(2);
        bchk("mcross", 1'b1, mcross);
        chk("osch", 16'h0003, {14'h0000, osch});
        rchk("pair", OFF_PAIR_CTRL, 16'ha0b0);
        cl = 16'h4321;
        clwe = 1;
        cyc(1);
        clwe = 0;
        rchk("clen", OFF_CABLE_LEN, 16'h4321);
        host.wr(OFF_LED_ONE, 16'h2d1c);
        host.wr(OFF_LED_TWO, 16'h4977);
        cyc(2);
        chk("ledoff", 16'h001b, {11'h000, l0, l0e, l1e, l2, l2e});
        st.link_up = 1;
        cyc(2);
        chk("ledon", 16'h001f, {10'h000, l0, l0e, l1, l1e, l2, l2e});
        k = 0;
        j = 0;
        repeat (104)
        begin
            cyc(1);
            k += flp;
            j += ledge;
        end
        chk("flp", 16'h0002, 16'(k));
        chk("ledge", 16'h000d, 16'(j));
        st.power_down = 1;
        cyc(8);
        k = 0;
        repeat (40)
        begin
            cyc(1);
            k += rxc;
        end
        chk("rxc", 16'h0014, 16'(k));
        bchk("rxcen", 1'b1, rxcen);
        host.wr(OFF_SPEC_CTRL, 16'h0026);
        cyc(4);
        chk("rxcoff", 16'h0000, {14'h0000, rxc, rxcen});
        slp = 1;
        cyc(1);
        slp = 0;
        k = 0;
        // Bounded wait; running out shows up as a wrong count
        while (!sdone && k < 300)
        begin
            cyc(1);
            k++;
        end
        chk("sleep", 16'h008c, 16'(k));
        // Second reset with the strap high
        strap = 1;
        i_rst = 1;
        cyc(2);
        i_rst = 0;
        cyc(2);
        bchk("mforce", 1'b1, mforce);
        bchk("irqrst", 1'b0, irq);
        rchk("strap", OFF_PAIR_CTRL, 16'ha0a0);
        tally_and_finish;
    end
endmodule
